// ### design/nvm_pkg.sv
// Constants, register map and carrier types for the data-flash controller.
// Assumes a processor core on one clock that writes special-function and
// secondary-bus registers through simple strobe ports.
package nvm_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] AREA_SELECT_OFS = 8'h20; // secondary bus
  localparam logic [7:0] ADDR_HIGH_OFS = 8'hf9;
  localparam logic [7:0] ADDR_LOW_OFS = 8'hfa;
  localparam logic [7:0] WRITE_DATA_OFS = 8'hfb;
  localparam logic [7:0] COMMAND_OFS = 8'hfc;
  localparam logic [7:0] ERASE_TIMING_OFS = 8'hfd;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] AREA_SELECT_RST = 8'h00;
  localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic [7:0] WRITE_DATA_RST = 8'h00;
  localparam logic [7:0] COMMAND_RST = 8'h00;
  localparam logic [7:0] ERASE_TIMING_RST = 8'h5a;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int AREA_SEL_BIT = 0;
  localparam int PAGE_SEL_BIT = 2;
  localparam logic [7:0] AREA_SELECT_MASK = 8'h01;
  localparam logic [7:0] ADDR_HIGH_MASK = 8'h07;
  localparam logic [4:0] TIM_FIELD_MAX = 5'h09;

  // ----------------------------------------------------------------------
  // Command codes and physical bases
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE = 8'h96;
  localparam logic [7:0] CMD_PROGRAM = 8'h69;
  localparam logic [15:0] BIG_BASE = 16'h3c00;
  localparam logic [15:0] SMALL0_BASE = 16'h4400;
  localparam logic [15:0] SMALL1_BASE = 16'h4600;

  // ----------------------------------------------------------------------
  // Timing: times in ns, counts in 100 ns cycles of mclk_i
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int PROG_NS = 23500;
  localparam int BIG_STEP_NS = 1000000;
  localparam int BIG_EXTRA_NS = 130000;
  localparam int SMALL_STEP_NS = 500000;
  localparam int SMALL_EXTRA_NS = 65000;
  localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIG_STEP_CYC = (BIG_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BIG_EXTRA_CYC = (BIG_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int SMALL_STEP_CYC = (SMALL_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SMALL_EXTRA_CYC = (SMALL_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic sec;        // 1: secondary-bus space, 0: special-function space
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic we;         // array write strobe
    logic erase;      // 1: page erase, 0: byte program
    logic [15:0] addr;
    logic [7:0] data;
  } array_req_t;

endpackage : nvm_pkg

// ### design/nvm_op_timer.sv
// Down-counter that times one erase or program operation.
// Assumes the load pulse arrives only while the counter is idle.
`timescale 1ns/1ps
module nvm_op_timer #(
  parameter int W = nvm_pkg::CNT_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] cycles_i,
  output logic busy_o,
  output logic done_o
);
  import nvm_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  // --------------------------------------------------------------------
  // Count down; done pulses the cycle after the last one
  // --------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (load_i)
    begin
      s_d.cnt = cycles_i;
      s_d.busy = 1'b1;
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt <= W'(1))
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.cnt = '0;
      end
      else
      begin
        s_d.cnt = s_q.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign busy_o = s_q.busy;
  assign done_o = s_q.done;

endmodule : nvm_op_timer

// ### design/nvm_ctrl.sv
// Data-flash erase and byte-program controller with its register file.
// Assumes the core writes registers with one-cycle strobes on mclk_i and
// that the array behind array_o accepts a strobe each time we is high.
// How it works
// - Area select clear: one 1024-byte page
// - Ten-bit logical address maps onto 0x3C00 up
// - Area select set: two 512-byte pages
// - First small page maps onto 0x4400-0x45FF
// - Second small page maps onto 0x4600-0x47FF
// - High address bit 2 picks small page
// - Small page offset: high bit 0, low byte
// - Big area needs high bit 2 clear; the decode ignores bit 2 in big mode
// - 0x96 erases page, 0x69 programs byte
// - Core clock halted while operation runs
// - Byte program always lasts 23.5 us
// - Big area erase: 1-10 ms plus 0.13
// - Small page erase: 0.5-5 ms plus 0.065
`timescale 1ns/1ps
module nvm_ctrl
  import nvm_pkg::*;
#(
  parameter int PROG_CYCLES = nvm_pkg::PROG_CYC,
  parameter int BIG_STEP = nvm_pkg::BIG_STEP_CYC,
  parameter int BIG_EXTRA = nvm_pkg::BIG_EXTRA_CYC,
  parameter int SMALL_STEP = nvm_pkg::SMALL_STEP_CYC,
  parameter int SMALL_EXTRA = nvm_pkg::SMALL_EXTRA_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire nvm_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic clk_halt_o,
  output nvm_pkg::array_req_t array_o
);
  import nvm_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_RUN
  } op_state_t;

  typedef struct packed {
    logic [7:0] area_sel;
    logic [7:0] addr_high;
    logic [7:0] addr_low;
    logic [7:0] wdata;
    logic [7:0] command;
    logic [7:0] timing;
    op_state_t st;
    logic erase;
    logic [CNT_W-1:0] cycles;
    logic [7:0] rdata;
    logic rvalid;
    logic halt;
    array_req_t arr;
  } ctrl_state_t;

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  logic tmr_load;
  logic tmr_busy;
  logic tmr_done;
  logic [15:0] phys_addr;
  logic [4:0] tim_eff;
  logic [CNT_W-1:0] erase_cycles;
  logic [CNT_W-1:0] erase_cycles_sel;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Bit 1 of the high register is ignored in small-page mode; bit 2 is
  // ignored in big mode since its set value is reserved for firmware.
  always_comb
  begin
    if (s_q.area_sel[AREA_SEL_BIT])
    begin
      if (s_q.addr_high[PAGE_SEL_BIT])
        phys_addr = SMALL1_BASE | {7'h00, s_q.addr_high[0], s_q.addr_low};
      else
        phys_addr = SMALL0_BASE | {7'h00, s_q.addr_high[0], s_q.addr_low};
    end
    else
    begin
      phys_addr = BIG_BASE | {6'h00, s_q.addr_high[1:0], s_q.addr_low};
    end
  end

  // --------------------------------------------------------------------
  // Erase duration; values above nine clamp to the longest setting
  // --------------------------------------------------------------------
  always_comb
  begin
    tim_eff = (s_q.timing[4:0] > TIM_FIELD_MAX) ? TIM_FIELD_MAX
                                                 : s_q.timing[4:0];
    if (s_q.area_sel[AREA_SEL_BIT])
      erase_cycles = CNT_W'((32'(tim_eff) + 32'd1) * SMALL_STEP
                            + SMALL_EXTRA);
    else
      erase_cycles = CNT_W'((32'(tim_eff) + 32'd1) * BIG_STEP + BIG_EXTRA);
  end

  // --------------------------------------------------------------------
  // Register file, command launch and operation sequencing
  // --------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.arr.we = 1'b0;
    tmr_load = 1'b0;
    // Writes are accepted only while idle; ST_START drops them, ST_RUN halts the core
    if (req_i.wr && s_q.st == ST_IDLE)
    begin
      if (req_i.sec)
      begin
        if (req_i.addr == AREA_SELECT_OFS)
          s_d.area_sel = req_i.wdata & AREA_SELECT_MASK;
      end
      else
      begin
        case (req_i.addr)
          ADDR_HIGH_OFS: s_d.addr_high = req_i.wdata & ADDR_HIGH_MASK;
          ADDR_LOW_OFS: s_d.addr_low = req_i.wdata;
          WRITE_DATA_OFS: s_d.wdata = req_i.wdata;
          ERASE_TIMING_OFS: s_d.timing = req_i.wdata;
          COMMAND_OFS:
          begin
            s_d.command = req_i.wdata;
            if (req_i.wdata == CMD_ERASE)
            begin
              s_d.st = ST_START;
              s_d.erase = 1'b1;
            end
            else if (req_i.wdata == CMD_PROGRAM)
            begin
              s_d.st = ST_START;
              s_d.erase = 1'b0;
            end
            // Any other code only stores the value
          end
          default: ;
        endcase
      end
    end
    if (req_i.rd)
    begin
      s_d.rvalid = 1'b1;
      if (req_i.sec)
        s_d.rdata = (req_i.addr == AREA_SELECT_OFS) ? s_q.area_sel : 8'h00;
      else
      begin
        case (req_i.addr)
          ADDR_HIGH_OFS: s_d.rdata = s_q.addr_high;
          ADDR_LOW_OFS: s_d.rdata = s_q.addr_low;
          WRITE_DATA_OFS: s_d.rdata = s_q.wdata;
          COMMAND_OFS: s_d.rdata = s_q.command;
          ERASE_TIMING_OFS: s_d.rdata = s_q.timing;
          default: s_d.rdata = 8'h00;
        endcase
      end
    end
    case (s_q.st)
      ST_START:
      begin
        // Launch: latch the address and halt the core clock
        tmr_load = 1'b1;
        s_d.halt = 1'b1;
        s_d.arr.we = 1'b1;
        s_d.arr.erase = s_q.erase;
        s_d.arr.addr = phys_addr;
        s_d.arr.data = s_q.wdata;
        s_d.cycles = s_q.erase ? erase_cycles
                               : CNT_W'(PROG_CYCLES);
        s_d.st = ST_RUN;
      end
      ST_RUN:
      begin
        if (tmr_done)
        begin
          s_d.halt = 1'b0;
          s_d.st = ST_IDLE;
        end
      end
      ST_IDLE: ;
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.area_sel <= AREA_SELECT_RST;
      s_q.addr_high <= ADDR_HIGH_RST;
      s_q.addr_low <= ADDR_LOW_RST;
      s_q.wdata <= WRITE_DATA_RST;
      s_q.command <= COMMAND_RST;
      s_q.timing <= ERASE_TIMING_RST;
      s_q.st <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  // --------------------------------------------------------------------
  // Operation timer
  // --------------------------------------------------------------------
  nvm_op_timer #(.W(CNT_W)) u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .cycles_i(erase_cycles_sel),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  assign erase_cycles_sel = s_d.cycles;

  assign rdata_o = s_q.rdata;
  assign rvalid_o = s_q.rvalid;
  assign clk_halt_o = s_q.halt;
  assign array_o = s_q.arr;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  // Erase steps from the raw field, clamped at the longest setting
  int unsigned erase_steps;
  assign erase_steps = (s_q.timing[4:0] > TIM_FIELD_MAX) ?
    32'(TIM_FIELD_MAX) + 32'd1 : 32'(s_q.timing[4:0]) + 32'd1;

  int unsigned halt_cnt;
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      halt_cnt <= 0;
    else if (s_q.halt)
      halt_cnt <= halt_cnt + 1;
    else
      halt_cnt <= 0;
  end

  erase_cmd_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && !req_i.sec && req_i.addr == COMMAND_OFS &&
    req_i.wdata == CMD_ERASE && s_q.st == ST_IDLE
    |-> ##2 array_o.we && array_o.erase && clk_halt_o)
    else $error("erase command did not launch");
  prog_cmd_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && !req_i.sec && req_i.addr == COMMAND_OFS &&
    req_i.wdata == CMD_PROGRAM && s_q.st == ST_IDLE
    |-> ##2 array_o.we && !array_o.erase)
    else $error("program command did not launch");
  bad_cmd_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    req_i.wr && !req_i.sec && req_i.addr == COMMAND_OFS &&
    req_i.wdata != CMD_PROGRAM && req_i.wdata != CMD_ERASE &&
    s_q.st == ST_IDLE |-> ##1 s_q.st == ST_IDLE ##1 !array_o.we)
    else $error("unknown command started an operation");
  big_map_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    array_o.we && !s_q.area_sel[AREA_SEL_BIT]
    |-> array_o.addr[15:10] == BIG_BASE[15:10])
    else $error("big area address out of range");
  big_ofs_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_q.st == ST_START && !s_q.area_sel[AREA_SEL_BIT]
    |=> array_o.addr[9:0] == {$past(s_q.addr_high[1:0]),
                              $past(s_q.addr_low)})
    else $error("big area offset wrong");
  small_pg_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_q.st == ST_START && s_q.area_sel[AREA_SEL_BIT]
    |=> array_o.addr[15:9] == ($past(s_q.addr_high[PAGE_SEL_BIT]) ?
        SMALL1_BASE[15:9] : SMALL0_BASE[15:9]))
    else $error("small page base wrong");
  small_ofs_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    s_q.st == ST_START && s_q.area_sel[AREA_SEL_BIT]
    |=> array_o.addr[8:0] == {$past(s_q.addr_high[0]),
                              $past(s_q.addr_low)})
    else $error("small page offset wrong");
  // Counter already holds the full halt length when the fall is seen
  prog_time_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $fell(clk_halt_o) && !array_o.erase
    |-> halt_cnt == PROG_CYCLES + 1)
    else $error("program duration wrong");
  // Measured halt length, so a broken timer load shows up here
  erase_time_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    $fell(clk_halt_o) && array_o.erase
    |-> halt_cnt == 1 + (s_q.area_sel[AREA_SEL_BIT] ?
        erase_steps * SMALL_STEP + SMALL_EXTRA :
        erase_steps * BIG_STEP + BIG_EXTRA))
    else $error("erase duration wrong");
  // Halt must track the timer in every cycle, launch and finish alike
  halt_track_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    clk_halt_o == (tmr_busy || tmr_done))
    else $error("halt and timer disagree");

  erase_run_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    array_o.we && array_o.erase);
  prog_run_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    array_o.we && !array_o.erase);
  small_run_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    array_o.we && s_q.area_sel[AREA_SEL_BIT]);
  resume_c: cover property (@(posedge mclk_i) disable iff (rst_i)
    $fell(clk_halt_o));

endmodule : nvm_ctrl

// ### dv/nvm_core_model.sv
// Core-side model: firmware register writes and reads on req_o.
// Assumes the controller takes one-cycle strobes on the rising edge.
`timescale 1ns/1ps
module nvm_core_model
  import nvm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic clk_halt_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output nvm_pkg::reg_req_t req_o
);
  initial req_o = '0;

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  // A frozen core issues nothing, so wait for the clock to run again
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    while (clk_halt_i !== 1'b0)
    begin
      @(posedge mclk_i);
      #1;
    end
    @(posedge mclk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, sec: s, addr: a, wdata: d};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, sec: s, addr: ~a, wdata: ~d};
  endtask : wr

  task automatic rd(input logic s, input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, sec: s, addr: a, wdata: 8'h00};
    @(posedge mclk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, sec: s, addr: ~a, wdata: 8'hff};
    n = 0;
    #1;
    while (rvalid_i !== 1'b1 && n < 4)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask : rd

  // ----------------------------------------------------------------------
  // Firmware sequences
  // ----------------------------------------------------------------------
  task automatic command(input logic [7:0] c);
    wr(1'b0, COMMAND_OFS, c);
    repeat (4) @(posedge mclk_i); // four no-ops
  endtask : command

  // Low address cleared before the page choice
  task automatic erase_page(input logic [7:0] hi);
    wr(1'b0, ADDR_LOW_OFS, 8'h00);
    wr(1'b0, ADDR_HIGH_OFS, hi);
    command(CMD_ERASE);
  endtask : erase_page

  task automatic prog_byte(input logic [7:0] hi, lo, d);
    wr(1'b0, ADDR_HIGH_OFS, hi);
    wr(1'b0, ADDR_LOW_OFS, lo);
    wr(1'b0, WRITE_DATA_OFS, d);
    command(CMD_PROGRAM);
  endtask : prog_byte
endmodule : nvm_core_model

// ### dv/data_flash_erase_program_ctrl_tb.sv
// Self-checking bench for the data-flash controller.
// Assumes short timing parameters; expectations derive from those values.
`timescale 1ns/1ps
module data_flash_erase_program_ctrl_tb;
  import nvm_pkg::*;
  localparam int PC = 5;
  localparam int BS = 20;
  localparam int BE = 3;
  localparam int SS = 10;
  localparam int SE = 2;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  reg_req_t req;
  logic [7:0] rdata_o;
  logic rvalid_o;
  logic clk_halt_o;
  array_req_t array_o;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h0000_e843;
  logic a;
  logic [7:0] hi, lo, d, t, v;
  logic [7:0] ofs_t [7] = '{8'h20, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'h21};
  logic [7:0] rst_t [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00};
  logic [7:0] tim_t [4] = '{8'h00, 8'h09, 8'h0a, 8'h1f};
  logic [7:0] bad_t [4] = '{8'h00, 8'h95, 8'h6a, 8'hff};

  // 100 ns clock matches CLK_NS; cycle figures come from the short parameters
  always #50 mclk_i = ~mclk_i;

  nvm_ctrl #(.PROG_CYCLES(PC), .BIG_STEP(BS), .BIG_EXTRA(BE),
    .SMALL_STEP(SS), .SMALL_EXTRA(SE)) u_dut (.mclk_i(mclk_i),
    .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .clk_halt_o(clk_halt_o), .array_o(array_o));

  nvm_core_model u_core (.mclk_i(mclk_i), .clk_halt_i(clk_halt_o),
    .rdata_i(rdata_o), .rvalid_i(rvalid_o), .req_o(req));

  // ----------------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------------
  function automatic logic [15:0] phys(input logic s, input logic [7:0] h, l);
    if (s)
      return (h[2] ? 16'h4600 : 16'h4400) + {7'h00, h[0], l};
    return 16'h3c00 + {6'h00, h[1:0], l};
  endfunction : phys

  // Fields above nine saturate at the longest erase
  function automatic int erase_len(input logic s, input logic [7:0] tm);
    int k;
    k = (tm[4:0] > 5'h09) ? 9 : int'(tm[4:0]);
    return s ? (k + 1) * SS + SE : (k + 1) * BS + BE;
  endfunction : erase_len

  task automatic check(input string nm, input logic [19:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, s);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Watch one launch: strobe, fields, then the length of the halt
  task automatic watch(input logic er, input logic [15:0] ad, input int len);
    int n;
    n = 0;
    while (array_o.we !== 1'b1 && n < 40)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    check("erase", array_o.erase, er);
    check("addr", array_o.addr, ad);
    if (!er)
      check("data", array_o.data, d);
    check("halt", clk_halt_o, 1'b1);
    n = 0;
    while (clk_halt_o === 1'b1 && n < 2000)
    begin
      @(posedge mclk_i);
      #1;
      n++;
      if (n == 1)
        check("we pulse", array_o.we, 1'b0);
    end
    check("halt cycles", 20'(n), 20'(len + 1));
  endtask : watch

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    check("reset outs", {clk_halt_o, rvalid_o, array_o.we}, 3'b000);
    for (int i = 0; i < 7; i++)
    begin
      u_core.rd(i == 0 || i == 6, ofs_t[i], v);
      check("reset value", v, rst_t[i]);
    end
    u_core.wr(1'b0, ADDR_HIGH_OFS, 8'hff);
    u_core.rd(1'b0, ADDR_HIGH_OFS, v);
    check("high mask", v, 8'h07);
    u_core.wr(1'b1, AREA_SELECT_OFS, 8'hff);
    u_core.rd(1'b1, AREA_SELECT_OFS, v);
    check("area mask", v, 8'h01);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      a = i[2];
      t = tim_t[i % 4];
      hi = a ? {5'h00, t[0], 2'b00} : 8'h00;
      u_core.wr(1'b1, AREA_SELECT_OFS, {7'h00, a});
      u_core.wr(1'b0, ERASE_TIMING_OFS, t);
      fork
        u_core.erase_page(hi);
        watch(1'b1, phys(a, hi, 8'h00), erase_len(a, t));
      join
    end
    $display("test erase done");
    // Programs follow the erases above, one write per location
    for (int k = 0; k < 12; k++)
    begin
      a = 1'($random(seed));
      hi = 8'($random(seed)) & (a ? 8'h05 : 8'h03);
      lo = 8'($random(seed));
      d = 8'($random(seed));
      if (k < 2)
      begin
        a = k[0];
        hi = a ? 8'h05 : 8'h03;
        lo = 8'hff;
      end
      u_core.wr(1'b1, AREA_SELECT_OFS, {7'h00, a});
      u_core.wr(1'b0, ERASE_TIMING_OFS, 8'($random(seed)));
      fork
        u_core.prog_byte(hi, lo, d);
        watch(1'b0, phys(a, hi, lo), PC);
      join
    end
    $display("test program done");
    for (int i = 0; i < 4; i++)
    begin
      fork
        u_core.command(bad_t[i]);
        repeat (12)
        begin
          @(posedge mclk_i);
          #1;
          check("no op", {array_o.we, clk_halt_o}, 2'b00);
        end
      join
      u_core.rd(1'b0, COMMAND_OFS, v);
      check("cmd reg", v, bad_t[i]);
    end
    $display("test unknown command done");
    u_core.wr(1'b0, ADDR_LOW_OFS, 8'h00);
    u_core.wr(1'b0, ADDR_HIGH_OFS, 8'h00);
    u_core.rd(1'b0, ADDR_HIGH_OFS, v);
    check("high cleared", v, 8'h00);
    $display("test wrap-up done");
    close_out();
  end

  // Whole run is under two thousand cycles; the 60000-cycle limit leaves ample margin
  initial
  begin
    #(100 * 60000);
    bad_count++;
    close_out();
  end
endmodule : data_flash_erase_program_ctrl_tb
